// *** verilog/foc_offset_ctrl.v ***
/*
 frequency offset control: control, shift, size, sync and data
 registers written byte-wise by the serial slave, input assembly in
 direct and streaming modes, absolute or relative update with
 saturation. assumes the slave logic runs on sys_clk and gives one
 write or read strobe per byte.
*/
// Notes on behaviour
// - control bit 4 picks direct byte writes (0) or streaming writes (1)
// - direct mode accepts writes to any of the four data bytes anytime
// - direct mode forms and applies a value only when the low byte is written
// - input uses size-many bytes from the low end, low byte at the bottom
// - input is sign-extended to 57 bits then shifted left by shift amount, at most 24
// - autoincrement disable applies to every register access
// - stream bytes come most significant first; width-th byte ends the value
// - streaming takes data only at the low byte, other data bytes ignored
// - control bit 5 picks absolute (0) or relative accumulation (1)
// - absolute mode saturates shifted input to 32 bits and loads it
// - relative mode adds in 57 bits, saturates to 32, stores sum
// - every offset update sets positive or negative clamp flag accordingly
// - control bit 6 enables offset operation
// - with bit 6 low other control bits ignored, clear still works
// - clear bit empties offset, holding registers and stream tracking, not shift
// - any control write restarts stream byte tracking
// - resync bit restarts stream tracking, next low byte is the first
`timescale 1ns/1ps
`include "foc_regs.vh"

module foc_offset_ctrl (
	input  wire        sys_clk,
	input  wire        reset_n,
	input  wire        regWrEn,
	input  wire        regRdEn,
	input  wire [7:0]  regAddr,
	input  wire [7:0]  regWrData,
	output reg  [7:0]  regRdData_r,
	output reg         autoIncDisable_r,
	output reg  [31:0] offsetValue_r,
	output reg         offsetUpdate_r,
	output reg         satPos_r,
	output reg         satNeg_r
);
	reg  [2:0]  ctrl_r;          // {ena, rel, stream}
	reg  [4:0]  shift_r;
	reg  [2:0]  size_r;
	wire [31:0] dataWord;        // big endian image, low byte at bits 7:0
	reg  [3:0]  byteSel;         // data byte hit, bit 0 is the low byte
	reg  [23:0] streamAsm_r;
	reg  [2:0]  streamCnt_r;
	reg  [31:0] raw;
	reg  [`FOC_EXT_W-1:0] ext;
	reg  [2:0]  width;
	reg  [4:0]  shiftEff;
	reg  [7:0]  regRdData_nxt;
	wire [`FOC_OFS_W-1:0] satVal;
	wire        clampP;
	wire        clampN;

	wire enable    = ctrl_r[2];
	wire streamMd  = ctrl_r[0] & enable;
	wire relMd     = ctrl_r[1] & enable;
	wire wrCtrl    = regWrEn & (regAddr == `FOC_ADDR_CTRL);
	wire wrSync    = regWrEn & (regAddr == `FOC_ADDR_SYNC);
	wire wrLow     = regWrEn & (regAddr == `FOC_ADDR_DATA_LOW);
	wire wrData    = regWrEn & (regAddr >= `FOC_ADDR_DATA) & (regAddr <= `FOC_ADDR_DATA_LOW);
	wire clearAll  = (wrCtrl & regWrData[`FOC_CTRL_CLR]) |
	                 (wrSync & regWrData[`FOC_SYNC_CLR]);
	wire resync    = wrCtrl | (wrSync & regWrData[`FOC_SYNC_RESYNC]);
	wire streamEnd = streamMd & wrLow & (streamCnt_r + 3'h1 >= width);
	wire directEnd = ~streamMd & wrLow;
	// a clear and a low byte write never share a cycle; clear wins anyway
	wire apply     = enable & (streamEnd | directEnd) & ~clearAll;

	always @* begin
		// zero and out-of-range sizes behave as full width
		width    = (size_r == 3'h0 || size_r > `FOC_SIZE_MAX) ? `FOC_SIZE_MAX : size_r;
		shiftEff = (shift_r > `FOC_SHIFT_MAX) ? `FOC_SHIFT_MAX : shift_r;
		if (streamMd) begin
			raw = {streamAsm_r, regWrData};
		end else begin
			raw = {dataWord[31:8], regWrData};
		end
		case (width)
			3'h1:    ext = {{49{raw[7]}}, raw[7:0]};
			3'h2:    ext = {{41{raw[15]}}, raw[15:0]};
			3'h3:    ext = {{33{raw[23]}}, raw[23:0]};
			default: ext = {{25{raw[31]}}, raw};
		endcase
		ext = ext << shiftEff;
		// 57 bits hold a shifted input plus the offset without wrapping
		if (relMd) begin
			ext = ext + {{25{offsetValue_r[31]}}, offsetValue_r};
		end
	end

	foc_saturate u_sat (
		.wide     (ext),
		.narrow   (satVal),
		.clampPos (clampP),
		.clampNeg (clampN)
	);

	always @* begin
		byteSel = 4'h0;
		case (regAddr)
			`FOC_ADDR_DATA:     byteSel = 4'h8;
			`FOC_ADDR_DATA_P1:  byteSel = 4'h4;
			`FOC_ADDR_DATA_P2:  byteSel = 4'h2;
			`FOC_ADDR_DATA_LOW: byteSel = 4'h1;
			default:            byteSel = 4'h0;
		endcase
	end

	always @* begin
		regRdData_nxt = 8'h00;
		case (regAddr)
			`FOC_ADDR_CTRL: begin
				regRdData_nxt[`FOC_CTRL_STREAM] = ctrl_r[0];
				regRdData_nxt[`FOC_CTRL_REL]    = ctrl_r[1];
				regRdData_nxt[`FOC_CTRL_ENA]    = ctrl_r[2];
			end
			`FOC_ADDR_SYNC: begin
				// write-one bits read back as zero
				regRdData_nxt[`FOC_SYNC_SATPOS] = satPos_r;
				regRdData_nxt[`FOC_SYNC_SATNEG] = satNeg_r;
			end
			`FOC_ADDR_SHIFT:    regRdData_nxt = {3'h0, shift_r};
			`FOC_ADDR_SIZE:     regRdData_nxt = {5'h00, size_r};
			`FOC_ADDR_DATA:     regRdData_nxt = dataWord[31:24];
			`FOC_ADDR_DATA_P1:  regRdData_nxt = dataWord[23:16];
			`FOC_ADDR_DATA_P2:  regRdData_nxt = dataWord[15:8];
			`FOC_ADDR_DATA_LOW: regRdData_nxt = dataWord[7:0];
			`FOC_ADDR_AUTOINC:  regRdData_nxt = {7'h00, autoIncDisable_r};
			default:            regRdData_nxt = 8'h00;
		endcase
	end

	// configuration registers; the clear leaves them alone
	always @(posedge sys_clk) begin
		if (!reset_n) begin
			ctrl_r           <= `FOC_CTRL_RST;
			shift_r          <= `FOC_SHIFT_RST;
			size_r           <= `FOC_SIZE_RST;
			autoIncDisable_r <= 1'b0;
		end else begin
			if (wrCtrl) begin
				ctrl_r <= {regWrData[`FOC_CTRL_ENA], regWrData[`FOC_CTRL_REL],
				           regWrData[`FOC_CTRL_STREAM]};
			end
			if (regWrEn && regAddr == `FOC_ADDR_SHIFT) begin
				shift_r <= regWrData[4:0];
			end
			if (regWrEn && regAddr == `FOC_ADDR_SIZE) begin
				size_r <= regWrData[2:0];
			end
			// slave logic reads this to hold its address on every access
			if (regWrEn && regAddr == `FOC_ADDR_AUTOINC) begin
				autoIncDisable_r <= regWrData[0];
			end
		end
	end

	always @(posedge sys_clk) begin
		if (!reset_n) begin
			regRdData_r <= 8'h00;
		end else if (regRdEn) begin
			regRdData_r <= regRdData_nxt;
		end
	end

	always @(posedge sys_clk) begin
		if (!reset_n || clearAll) begin
			streamAsm_r <= 24'h000000;
			streamCnt_r <= 3'h0;
		end else if (resync) begin
			streamAsm_r <= 24'h000000;
			streamCnt_r <= 3'h0;
		end else if (streamMd && wrLow) begin
			// bytes shift up so the last one lands lowest
			streamAsm_r <= streamEnd ? 24'h000000 : {streamAsm_r[15:0], regWrData};
			streamCnt_r <= streamEnd ? 3'h0 : streamCnt_r + 3'h1;
		end
	end

	// one holding byte per data location, byte 0 is the low byte
	genvar gByte;
	generate
		for (gByte = 0; gByte < 4; gByte = gByte + 1) begin : g_data
			reg  [7:0] dataByte_r;
			// streaming drops writes to the upper three bytes
			wire       take = wrData & byteSel[gByte] & (~streamMd | (gByte == 0));
			always @(posedge sys_clk) begin
				if (!reset_n || clearAll) begin
					dataByte_r <= 8'h00;
				end else if (take) begin
					dataByte_r <= regWrData;
				end
			end
			assign dataWord[8*gByte+7:8*gByte] = dataByte_r;
		end
	endgenerate

	always @(posedge sys_clk) begin
		if (!reset_n) begin
			offsetValue_r  <= 32'h00000000;
			offsetUpdate_r <= 1'b0;
			satPos_r       <= 1'b0;
			satNeg_r       <= 1'b0;
		end else begin
			offsetUpdate_r <= apply;
			if (clearAll) begin
				offsetValue_r <= 32'h00000000;
				satPos_r      <= 1'b0;
				satNeg_r      <= 1'b0;
			end else if (apply) begin
				offsetValue_r <= satVal;
				satPos_r      <= clampP;
				satNeg_r      <= clampN;
			end
		end
	end
endmodule // foc_offset_ctrl

// *** inc/foc_regs.vh ***
/*
 register map, field positions, reset values and limits of the
 frequency offset control block; assumes byte-wide register access.
*/
`ifndef FOC_REGS_VH
`define FOC_REGS_VH

`define FOC_ADDR_CTRL      8'h19
`define FOC_ADDR_SYNC      8'h1A
`define FOC_ADDR_SHIFT     8'h1B
`define FOC_ADDR_SIZE      8'h1C
`define FOC_ADDR_DATA      8'h1D
`define FOC_ADDR_DATA_P1   8'h1E
`define FOC_ADDR_DATA_P2   8'h1F
`define FOC_ADDR_DATA_LOW  8'h20
`define FOC_ADDR_AUTOINC   8'h22

`define FOC_CTRL_STREAM    4
`define FOC_CTRL_REL       5
`define FOC_CTRL_ENA       6
`define FOC_CTRL_CLR       7
`define FOC_SYNC_RESYNC    0
`define FOC_SYNC_CLR       1
`define FOC_SYNC_SATNEG    6
`define FOC_SYNC_SATPOS    7

`define FOC_CTRL_RST       3'h0
`define FOC_SHIFT_RST      5'h00
`define FOC_SIZE_RST       3'h0
`define FOC_SHIFT_MAX      5'h18
`define FOC_SIZE_MAX       3'h4
`define FOC_EXT_W          57
`define FOC_OFS_W          32

`endif

// *** verilog/foc_saturate.v ***
/*
 sign saturation of a 57-bit value to 32 bits with clamp flags;
 purely combinational, the caller registers the results.
*/
`timescale 1ns/1ps
`include "foc_regs.vh"

module foc_saturate (
	input  wire [`FOC_EXT_W-1:0] wide,
	output reg  [`FOC_OFS_W-1:0] narrow,
	output reg                   clampPos,
	output reg                   clampNeg
);
	wire fits = (&wide[`FOC_EXT_W-1:`FOC_OFS_W-1]) | ~(|wide[`FOC_EXT_W-1:`FOC_OFS_W-1]);

	always @* begin
		clampPos = ~fits & ~wide[`FOC_EXT_W-1];
		clampNeg = ~fits & wide[`FOC_EXT_W-1];
		if (clampPos) begin
			narrow = 32'h7FFFFFFF;
		end else if (clampNeg) begin
			narrow = 32'h80000000;
		end else begin
			narrow = wide[`FOC_OFS_W-1:0];
		end
	end
endmodule // foc_saturate

// *** tb/foc_offset_ctrl_sva.sv ***
/*
 checker for foc_offset_ctrl port behaviour.
 assumes reset held two or more edges.
*/
`timescale 1ns/1ps
`include "foc_regs.vh"
module foc_offset_ctrl_sva (
	input wire        sys_clk,
	input wire        reset_n,
	input wire        regWrEn,
	input wire        regRdEn,
	input wire [7:0]  regAddr,
	input wire [7:0]  regWrData,
	input wire [7:0]  regRdData_r,
	input wire        autoIncDisable_r,
	input wire [31:0] offsetValue_r,
	input wire        offsetUpdate_r,
	input wire        satPos_r,
	input wire        satNeg_r
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	wire ctrlWr = regWrEn && regAddr == `FOC_ADDR_CTRL;
	wire clrWr  = (ctrlWr && regWrData[7]) || (regWrEn && regAddr == `FOC_ADDR_SYNC && regWrData[1]);
	property p_src; offsetUpdate_r |-> $past(regWrEn) && $past(regAddr) == `FOC_ADDR_DATA_LOW; endproperty
	a_src: assert property (p_src) else $error("update without low byte write");
	property p_hold; $changed(offsetValue_r) |-> offsetUpdate_r || $past(clrWr); endproperty
	a_hold: assert property (p_hold) else $error("offset moved without cause");
	property p_clr; clrWr |=> offsetValue_r == 32'h0 && !satPos_r && !satNeg_r; endproperty
	a_clr: assert property (p_clr) else $error("clear missed");
	property p_pos; satPos_r |-> offsetValue_r == 32'h7FFFFFFF; endproperty
	a_pos: assert property (p_pos) else $error("bad positive clamp");
	property p_neg; satNeg_r |-> offsetValue_r == 32'h80000000; endproperty
	a_neg: assert property (p_neg) else $error("bad negative clamp");
	property p_flag; !offsetUpdate_r && !$past(clrWr) |-> $stable(satPos_r) && $stable(satNeg_r); endproperty
	a_flag: assert property (p_flag) else $error("flags moved without update");
	property p_inc; regWrEn && regAddr == `FOC_ADDR_AUTOINC |=> autoIncDisable_r == $past(regWrData[0]); endproperty
	a_inc: assert property (p_inc) else $error("autoincrement flag wrong");
	property p_unm; regRdEn && regAddr == 8'h00 |=> regRdData_r == 8'h00; endproperty
	a_unm: assert property (p_unm) else $error("unmapped read not zero");
	property p_dis; ctrlWr && !regWrData[`FOC_CTRL_ENA] |=> !offsetUpdate_r [*2]; endproperty
	a_dis: assert property (p_dis) else $error("update while disabled");
endmodule // foc_offset_ctrl_sva
bind foc_offset_ctrl foc_offset_ctrl_sva u_sva (.*);

// *** tb/foc_host_model.sv ***
/*
 host side: byte write and read strobes toward the block.
 assumes the bench calls its tasks one at a time.
*/
`timescale 1ns/1ps
`include "foc_regs.vh"
module foc_host_model (
	input  wire       sys_clk,
	input  wire [7:0] rdData,
	output reg        regWrEn,
	output reg        regRdEn,
	output reg  [7:0] regAddr,
	output reg  [7:0] regWrData
);
	initial begin
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		regAddr = 8'h00;
		regWrData = 8'h00;
	end
	// released lines show inverted values, never a stale match
	task wr(input [7:0] a, input [7:0] d);
		@(negedge sys_clk);
		regWrEn = 1'b1;
		regAddr = a;
		regWrData = d;
		@(negedge sys_clk);
		regWrEn = 1'b0;
		regAddr = ~a;
		regWrData = ~d;
	endtask
	task rd(input [7:0] a, output [7:0] q);
		@(negedge sys_clk);
		regRdEn = 1'b1;
		regAddr = a;
		@(negedge sys_clk);
		q = rdData;
		regRdEn = 1'b0;
		regAddr = ~a;
	endtask
	task strm(input [31:0] v, input integer n);
		integer i;
		for (i = n - 1; i >= 0; i = i - 1) wr(`FOC_ADDR_DATA_LOW, v[8*i+:8]);
	endtask
endmodule // foc_host_model

// *** tb/foc_offset_ctrl_bench.sv ***
/*
 bench for foc_offset_ctrl: register sequences with expected values.
 assumes host model strobes and 125 MHz clock.
*/
`timescale 1ns/1ps
`include "foc_regs.vh"
module foc_offset_ctrl_bench;
	reg         sys_clk, reset_n;
	wire        regWrEn, regRdEn, autoIncDisable_r, offsetUpdate_r, satPos_r, satNeg_r;
	wire [7:0]  regAddr, regWrData, regRdData_r;
	wire [31:0] offsetValue_r;
	reg  [7:0]  q;
	integer     miscompares, num_checks;
	foc_host_model host (.sys_clk(sys_clk), .rdData(regRdData_r), .regWrEn(regWrEn),
		.regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData));
	foc_offset_ctrl dut (.sys_clk(sys_clk), .reset_n(reset_n), .regWrEn(regWrEn),
		.regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
		.regRdData_r(regRdData_r), .autoIncDisable_r(autoIncDisable_r),
		.offsetValue_r(offsetValue_r), .offsetUpdate_r(offsetUpdate_r),
		.satPos_r(satPos_r), .satNeg_r(satNeg_r));
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	task chk(input [31:0] got, input [31:0] exp);
		num_checks = num_checks + 1;
		if (got !== exp) begin
			miscompares = miscompares + 1;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task print_verdict;
		if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		miscompares = 0;
		num_checks = 0;
		reset_n = 1'b0;
		repeat (5) @(posedge sys_clk);
		@(negedge sys_clk) reset_n = 1'b1;
		host.rd(`FOC_ADDR_CTRL, q);
		chk({24'h000000, q}, 32'h0);
		host.wr(`FOC_ADDR_CTRL, 8'h40);
		host.wr(`FOC_ADDR_DATA_P2, 8'h56);
		host.wr(`FOC_ADDR_DATA, 8'h12);
		host.wr(`FOC_ADDR_DATA_P1, 8'h34);
		chk(offsetValue_r, 32'h0);
		host.wr(`FOC_ADDR_DATA_LOW, 8'h78);
		chk({31'h0, offsetUpdate_r}, 32'h1);
		chk(offsetValue_r, 32'h12345678);
		host.wr(`FOC_ADDR_SIZE, 8'h01);
		host.wr(`FOC_ADDR_DATA_LOW, 8'h80);
		chk(offsetValue_r, 32'hFFFFFF80);
		host.wr(`FOC_ADDR_SIZE, 8'h00);
		host.wr(`FOC_ADDR_SHIFT, 8'h04);
		host.wr(`FOC_ADDR_DATA_LOW, 8'h78);
		chk(offsetValue_r, 32'h7FFFFFFF);
		chk({30'h0, satPos_r, satNeg_r}, 32'h2);
		host.wr(`FOC_ADDR_DATA, 8'hF2);
		host.wr(`FOC_ADDR_DATA_LOW, 8'h78);
		chk({30'h0, satPos_r, satNeg_r}, 32'h1);
		chk(offsetValue_r, 32'h80000000);
		host.wr(`FOC_ADDR_CTRL, 8'hE0);
		chk(offsetValue_r, 32'h0);
		chk({30'h0, satPos_r, satNeg_r}, 32'h0);
		host.rd(`FOC_ADDR_SHIFT, q);
		chk({24'h000000, q}, 32'h4);
		host.wr(`FOC_ADDR_SHIFT, 8'h00);
		host.wr(`FOC_ADDR_SIZE, 8'h01);
		host.wr(`FOC_ADDR_DATA_LOW, 8'h05);
		host.wr(`FOC_ADDR_DATA_LOW, 8'hF0);
		chk(offsetValue_r, 32'hFFFFFFF5);
		host.wr(`FOC_ADDR_CTRL, 8'h20);
		host.wr(`FOC_ADDR_DATA_LOW, 8'h01);
		chk({31'h0, offsetUpdate_r}, 32'h0);
		chk(offsetValue_r, 32'hFFFFFFF5);
		host.wr(`FOC_ADDR_CTRL, 8'h80);
		chk(offsetValue_r, 32'h0);
		host.wr(`FOC_ADDR_AUTOINC, 8'h01);
		chk({31'h0, autoIncDisable_r}, 32'h1);
		host.wr(`FOC_ADDR_CTRL, 8'h50);
		host.wr(`FOC_ADDR_SIZE, 8'h02);
		host.wr(`FOC_ADDR_DATA_P2, 8'hFF);
		host.strm(32'h1234, 2);
		chk(offsetValue_r, 32'h1234);
		host.rd(`FOC_ADDR_DATA_P2, q);
		chk({24'h000000, q}, 32'h0);
		host.wr(`FOC_ADDR_DATA_LOW, 8'hAB);
		host.wr(`FOC_ADDR_SYNC, 8'h01);
		host.strm(32'h0001, 2);
		chk(offsetValue_r, 32'h1);
		host.wr(`FOC_ADDR_DATA_LOW, 8'hAB);
		host.wr(`FOC_ADDR_CTRL, 8'h50);
		host.strm(32'h0002, 2);
		chk(offsetValue_r, 32'h2);
		host.rd(8'h00, q);
		chk({24'h000000, q}, 32'h0);
		print_verdict;
	end
endmodule // foc_offset_ctrl_bench
